// File: common/slm_pkg.sv
/*
  Shared constants and types for the safely limited speed monitor: register map,
  field layout, reset values, timing base and channel state encoding.
  Assumes a 50 MHz system clock and speed words in units of 0.1 rpm.
*/
package slm_pkg;
  // sizes
  localparam int NUM_CH = 4;
  localparam int NUM_DI = 8;
  localparam int NUM_DO = 8;
  localparam int SEL_W = 3;
  localparam int SPD_W = 16;
  localparam int TIME_W = 16;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int EVT_W = 2 * NUM_CH;
  // timing base: all delays count 1 ms ticks
  localparam int CLK_PERIOD_NS = 20;
  localparam int TICK_PERIOD_NS = 1000000;
  // per-channel register block, channel c sits at c * CH_STRIDE
  localparam logic [ADDR_W-1:0] CH_STRIDE = 8'h20;
  localparam logic [ADDR_W-1:0] CH_OFF_MASK = 8'h1F;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_LIM_NEG = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_LIM_POS = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_TRIP_NEG = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_TRIP_POS = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_ACT_DLY = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_MOD_DLY = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_RAMP = 8'h1C;
  // global registers
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h80;
  localparam logic [ADDR_W-1:0] OFF_MASK = 8'h84;
  localparam logic [ADDR_W-1:0] OFF_STATE = 8'h88;
  localparam logic [ADDR_W-1:0] OFF_CFG = 8'h8C;
  // control word fields
  localparam int CTRL_W = 11;
  localparam int CTRL_ACT_LSB = 0;
  localparam int ACT_W = 2;
  localparam int CTRL_ACK_BIT = 2;
  localparam int CTRL_RAMP_BIT = 3;
  localparam int CTRL_MODD_BIT = 4;
  localparam int CTRL_IN_LSB = 5;
  localparam int CTRL_OUT_LSB = 8;
  localparam int RAMP_INIT_LSB = 16;
  localparam int CFG_ENC_BIT = 0;
  localparam logic [ACT_W-1:0] ACT_V1 = 2'h1;
  // reset values: version 1, auto ack, ramp monitoring, delayed modulation reaction
  localparam logic [CTRL_W-1:0] CTRL_RST = 11'h01D;
  localparam logic [SPD_W-1:0] LIM_NEG_RST = 16'hF830;   // -200.0 rpm
  localparam logic [SPD_W-1:0] LIM_POS_RST = 16'h07D0;   // 200.0 rpm
  localparam logic [SPD_W-1:0] TRIP_NEG_RST = 16'hF63C;  // -250.0 rpm
  localparam logic [SPD_W-1:0] TRIP_POS_RST = 16'h09C4;  // 250.0 rpm
  localparam logic [TIME_W-1:0] ACT_DLY_RST_MS = 16'h0FA0;  // 4000 ms
  localparam logic [TIME_W-1:0] MOD_DLY_RST_MS = 16'h0000;  // 0 ms
  localparam logic [SPD_W-1:0] RAMP_STEP_RST = 16'h0008;    // 0.8 rpm per ms
  localparam logic [TIME_W-1:0] RAMP_INIT_RST_MS = 16'h0064; // 100 ms
  typedef enum logic [1:0] {
    SLM_IDLE = 2'b00,
    SLM_RAMP = 2'b01,
    SLM_ACTIVE = 2'b10,
    SLM_ACKWAIT = 2'b11
  } slm_state_t;
endpackage

// File: hdl/slm_chan.sv
/*
  One speed limit supervision channel: request handling, activation by time
  delay or monitored ramp, modulation loss reaction, trip latch and indication.
  Assumes synchronous inputs, a one-cycle 1 ms tick and a one-cycle ack pulse.
*/
`timescale 1ns/100ps
module slm_chan (
  input wire logic clk,
  input wire logic rst,
  input wire logic en,
  input wire logic ack_auto,
  input wire logic ramp_mode,
  input wire logic mod_delay_mode,
  input wire logic encoder_used,
  input wire logic signed [slm_pkg::SPD_W-1:0] lim_neg,
  input wire logic signed [slm_pkg::SPD_W-1:0] lim_pos,
  input wire logic signed [slm_pkg::SPD_W-1:0] trip_neg,
  input wire logic signed [slm_pkg::SPD_W-1:0] trip_pos,
  input wire logic [slm_pkg::TIME_W-1:0] act_dly,
  input wire logic [slm_pkg::TIME_W-1:0] mod_dly,
  input wire logic [slm_pkg::SPD_W-1:0] ramp_step,
  input wire logic [slm_pkg::TIME_W-1:0] ramp_init,
  input wire logic ms_tick,
  input wire logic req,
  input wire logic modulating,
  input wire logic ack_pulse,
  input wire logic signed [slm_pkg::SPD_W-1:0] speed,
  output logic ind,
  output logic trip
);
  import slm_pkg::*;
  slm_state_t st_r, st_nxt;
  logic [TIME_W-1:0] cnt_r, cnt_nxt, mod_cnt_r, mod_cnt_nxt;
  logic [SPD_W:0] env_r, env_nxt;
  logic trip_r, trip_nxt;

  // speed classification against the configured bounds
  wire signed [SPD_W:0] spd_x = {speed[SPD_W-1], speed};
  wire [SPD_W:0] abs_spd = spd_x[SPD_W] ? -spd_x : spd_x;
  wire in_lim = (speed >= lim_neg) && (speed <= lim_pos);
  wire over_rev = speed < trip_neg;
  wire over_fwd = speed > trip_pos;
  wire supv = (st_r == SLM_ACTIVE) || (st_r == SLM_ACKWAIT);
  // with encoder feedback modulation loss is not a fault at all
  wire mod_lost = !modulating && !encoder_used;
  wire mod_trip = mod_lost && (!mod_delay_mode || mod_cnt_r >= mod_dly);
  wire ramp_trip = ramp_mode && (abs_spd > env_r);
  wire [SPD_W:0] step_x = {1'b0, ramp_step};
  wire [SPD_W:0] env_dec = (env_r > step_x) ? env_r - step_x : '0;
  wire tick_cnt = ms_tick && !(&cnt_r);
  wire tick_mod = ms_tick && !(&mod_cnt_r);

  // next state; trip set wins over the acknowledge clear
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    env_nxt = env_r;
    mod_cnt_nxt = (st_r == SLM_RAMP && mod_lost) ? mod_cnt_r + TIME_W'(tick_mod) : '0;
    trip_nxt = trip_r && !(ack_pulse && !req);
    unique case (st_r)
      SLM_IDLE: begin
        if (req) begin
          st_nxt = in_lim ? SLM_ACTIVE : SLM_RAMP;
          cnt_nxt = '0;
          env_nxt = abs_spd;
        end
      end
      SLM_RAMP: begin
        cnt_nxt = cnt_r + TIME_W'(tick_cnt);
        // envelope holds during the initial allowance, then falls per ms
        if (ramp_mode && ms_tick && cnt_r >= ramp_init) begin
          env_nxt = env_dec;
        end
        if (!req) begin
          st_nxt = SLM_IDLE;
        end else if (ramp_mode ? in_lim : (cnt_r >= act_dly)) begin
          st_nxt = SLM_ACTIVE;
        end
        if (req && (ramp_trip || mod_trip)) begin
          trip_nxt = 1'b1;
        end
      end
      SLM_ACTIVE: begin
        if (!req && !ack_auto) begin
          st_nxt = SLM_ACKWAIT;
        end else if (!req && in_lim) begin
          st_nxt = SLM_IDLE;
        end
      end
      SLM_ACKWAIT: begin
        if (req) begin
          st_nxt = SLM_ACTIVE;
        end else if (ack_pulse) begin
          st_nxt = SLM_IDLE;
        end
      end
    endcase
    if (supv && (over_rev || over_fwd)) begin
      trip_nxt = 1'b1;
    end
    if (!en) begin
      st_nxt = SLM_IDLE;
      trip_nxt = 1'b0;
    end
  end

  // state registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= SLM_IDLE;
      cnt_r <= '0;
      mod_cnt_r <= '0;
      env_r <= '0;
      trip_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      mod_cnt_r <= mod_cnt_nxt;
      env_r <= env_nxt;
      trip_r <= trip_nxt;
    end
  end

  assign ind = supv;
  assign trip = trip_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  rev_trip_a: assert property (en && supv && over_rev |=> trip)
    else $error("reverse trip threshold exceeded without trip");
  fwd_trip_a: assert property (en && supv && over_fwd |=> trip)
    else $error("forward trip threshold exceeded without trip");
  limit_quiet_a: assert property (en && req && st_r == SLM_ACTIVE && in_lim && !trip ##1 en && req |-> !trip && ind)
    else $error("trip or lost indication while inside limits");
  auto_ack_a: assert property (en && ack_auto && st_r == SLM_ACTIVE && !req && in_lim |=> st_r == SLM_IDLE)
    else $error("automatic acknowledge did not end supervision");
  time_act_a: assert property (en && req && !ramp_mode && st_r == SLM_RAMP && cnt_r >= act_dly |=> ind)
    else $error("activation delay elapsed without supervision");
  ramp_env_a: assert property (en && req && st_r == SLM_RAMP && ramp_mode && abs_spd > env_r |=> trip)
    else $error("speed above ramp envelope without trip");
  mod_now_a: assert property (en && req && st_r == SLM_RAMP && !mod_delay_mode && mod_lost |=> trip)
    else $error("modulation loss did not trip at once");
  mod_delay_a: assert property (en && req && st_r == SLM_RAMP && mod_lost && mod_cnt_r >= mod_dly |=> trip)
    else $error("modulation loss delay elapsed without trip");
  // any trip here could only come from modulation loss, which the encoder masks
  enc_ignore_a: assert property (en && encoder_used && st_r == SLM_RAMP && !trip && !ramp_trip |=> !trip)
    else $error("modulation loss acted with encoder feedback");
endmodule

// File: hdl/slm_sync.sv
/*
  Two-stage synchroniser for a group of pin levels.
  Assumes each bit is an independent slow level; no bus coherency is implied.
*/
`timescale 1ns/100ps
module slm_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  // a zero-width group has nothing to carry
  if (W < 1) begin : g_bad_w
    $error("W must be at least 1");
  end

  // first stage feeds only the second stage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

// File: hdl/slm_top.sv
/*
  Safely limited speed monitor top: APB register file, pin synchronisers,
  1 ms tick, four supervision channels, input and output routing, interrupt.
  Assumes SPEED is produced by logic on SYS_CLK; DIN, MODULATING and
  ACK_BUTTON are asynchronous pins.
*/
`timescale 1ns/100ps
module slm_top #(
  parameter int TICK_CYCLES = slm_pkg::TICK_PERIOD_NS / slm_pkg::CLK_PERIOD_NS
) (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [slm_pkg::ADDR_W-1:0] PADDR,
  input wire logic [slm_pkg::DATA_W-1:0] PWDATA,
  output logic [slm_pkg::DATA_W-1:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic signed [slm_pkg::SPD_W-1:0] SPEED,
  input wire logic [slm_pkg::NUM_DI-1:0] DIN,
  input wire logic MODULATING,
  input wire logic ACK_BUTTON,
  output logic [slm_pkg::NUM_DO-1:0] DOUT,
  output logic TRIP,
  output logic IRQ
);
  import slm_pkg::*;
  localparam int TICK_W = $clog2(TICK_CYCLES);
  localparam int PIN_W = NUM_DI + 2;
  localparam int PIN_MOD = NUM_DI;
  localparam int PIN_ACK = NUM_DI + 1;

  // refuse settings the tick counter or the select fields cannot serve
  if (TICK_CYCLES < 2) begin : g_bad_tick
    $error("TICK_CYCLES must be at least 2");
  end
  if (NUM_DI > (1 << SEL_W) || NUM_DO > (1 << SEL_W)) begin : g_bad_sel
    $error("select fields too narrow for pin count");
  end

  logic [PIN_W-1:0] pin_s;
  logic ack_d_r;
  logic [TICK_W-1:0] tick_cnt_r;
  logic tick_r;
  logic [CTRL_W-1:0] ctrl_r [NUM_CH];
  logic [SPD_W-1:0] lneg_r [NUM_CH];
  logic [SPD_W-1:0] lpos_r [NUM_CH];
  logic [SPD_W-1:0] tneg_r [NUM_CH];
  logic [SPD_W-1:0] tpos_r [NUM_CH];
  logic [TIME_W-1:0] adly_r [NUM_CH];
  logic [TIME_W-1:0] mdly_r [NUM_CH];
  logic [SPD_W-1:0] step_r [NUM_CH];
  logic [TIME_W-1:0] init_r [NUM_CH];
  logic [DATA_W-1:0] ch_rd [NUM_CH];
  logic [DATA_W-1:0] rd_acc [NUM_CH+1];
  logic [SEL_W-1:0] in_sel [NUM_CH];
  logic [SEL_W-1:0] out_sel [NUM_CH];
  logic [NUM_CH-1:0] ch_sel, en_w, req_w, ind_w, trip_w, ind_d_r, trip_d_r;
  logic [EVT_W-1:0] status_r, status_nxt, mask_r;
  logic cfg_enc_r;
  logic [NUM_DO-1:0] dout_nxt, dout_r;
  logic [DATA_W-1:0] prdata_r;

  // pins pass two flops before any logic looks at them
  slm_sync #(.W(PIN_W)) u_sync (
    .clk(SYS_CLK),
    .rst(RST),
    .d({ACK_BUTTON, MODULATING, DIN}),
    .q(pin_s)
  );
  wire ack_pulse = pin_s[PIN_ACK] && !ack_d_r;
  wire mod_s = pin_s[PIN_MOD];

  // 1 ms time base, shared by every channel's delays
  wire tick_wrap = tick_cnt_r == TICK_W'(TICK_CYCLES - 1);
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      tick_cnt_r <= '0;
      tick_r <= 1'b0;
      ack_d_r <= 1'b0;
    end else begin
      tick_cnt_r <= tick_wrap ? '0 : tick_cnt_r + TICK_W'(1);
      tick_r <= tick_wrap;
      ack_d_r <= pin_s[PIN_ACK];
    end
  end

  // bus decode; the slave answers in the first access cycle
  wire apb_setup = PSEL && !PENABLE;
  wire apb_access = PSEL && PENABLE;
  wire aligned = PADDR[1:0] == 2'h0;
  wire [ADDR_W-1:0] off = PADDR & CH_OFF_MASK;
  wire [ADDR_W-1:0] ch_base = PADDR & ~CH_OFF_MASK;
  wire glb_hit = (PADDR == OFF_STATUS) || (PADDR == OFF_MASK) || (PADDR == OFF_STATE) || (PADDR == OFF_CFG);
  wire hit = aligned && ((|ch_sel) || glb_hit);
  wire apb_wr = apb_access && PWRITE && hit;

  // per-channel register block, settings and supervision instance
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    localparam logic [ADDR_W-1:0] BASE = ADDR_W'(c * CH_STRIDE);
    localparam logic [CTRL_W-1:0] CTRL_C = CTRL_RST | CTRL_W'(c << CTRL_IN_LSB) | CTRL_W'(c << CTRL_OUT_LSB);
    assign ch_sel[c] = aligned && (ch_base == BASE);
    wire wr = apb_wr && ch_sel[c];

    always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
        ctrl_r[c] <= CTRL_C;
        lneg_r[c] <= LIM_NEG_RST;
        lpos_r[c] <= LIM_POS_RST;
        tneg_r[c] <= TRIP_NEG_RST;
        tpos_r[c] <= TRIP_POS_RST;
        adly_r[c] <= ACT_DLY_RST_MS;
        mdly_r[c] <= MOD_DLY_RST_MS;
        step_r[c] <= RAMP_STEP_RST;
        init_r[c] <= RAMP_INIT_RST_MS;
      end else if (wr) begin
        if (off == OFF_CTRL) ctrl_r[c] <= PWDATA[CTRL_W-1:0];
        if (off == OFF_LIM_NEG) lneg_r[c] <= PWDATA[SPD_W-1:0];
        if (off == OFF_LIM_POS) lpos_r[c] <= PWDATA[SPD_W-1:0];
        if (off == OFF_TRIP_NEG) tneg_r[c] <= PWDATA[SPD_W-1:0];
        if (off == OFF_TRIP_POS) tpos_r[c] <= PWDATA[SPD_W-1:0];
        if (off == OFF_ACT_DLY) adly_r[c] <= PWDATA[TIME_W-1:0];
        if (off == OFF_MOD_DLY) mdly_r[c] <= PWDATA[TIME_W-1:0];
        if (off == OFF_RAMP) step_r[c] <= PWDATA[SPD_W-1:0];
        if (off == OFF_RAMP) init_r[c] <= PWDATA[RAMP_INIT_LSB +: TIME_W];
      end
    end

    // activity reads back as written, so value one shows the version
    assign en_w[c] = ctrl_r[c][CTRL_ACT_LSB +: ACT_W] == ACT_V1;
    assign in_sel[c] = ctrl_r[c][CTRL_IN_LSB +: SEL_W];
    assign out_sel[c] = ctrl_r[c][CTRL_OUT_LSB +: SEL_W];
    assign req_w[c] = pin_s[in_sel[c]];

    // read path; unused upper bits read as zero
    assign ch_rd[c] = !ch_sel[c] ? '0 :
      (off == OFF_CTRL) ? DATA_W'(ctrl_r[c]) :
      (off == OFF_LIM_NEG) ? DATA_W'(lneg_r[c]) :
      (off == OFF_LIM_POS) ? DATA_W'(lpos_r[c]) :
      (off == OFF_TRIP_NEG) ? DATA_W'(tneg_r[c]) :
      (off == OFF_TRIP_POS) ? DATA_W'(tpos_r[c]) :
      (off == OFF_ACT_DLY) ? DATA_W'(adly_r[c]) :
      (off == OFF_MOD_DLY) ? DATA_W'(mdly_r[c]) :
      {init_r[c], step_r[c]};
    assign rd_acc[c+1] = rd_acc[c] | ch_rd[c];

    slm_chan u_chan (
      .clk(SYS_CLK),
      .rst(RST),
      .en(en_w[c]),
      .ack_auto(ctrl_r[c][CTRL_ACK_BIT]),
      .ramp_mode(ctrl_r[c][CTRL_RAMP_BIT]),
      .mod_delay_mode(ctrl_r[c][CTRL_MODD_BIT]),
      .encoder_used(cfg_enc_r),
      .lim_neg(lneg_r[c]),
      .lim_pos(lpos_r[c]),
      .trip_neg(tneg_r[c]),
      .trip_pos(tpos_r[c]),
      .act_dly(adly_r[c]),
      .mod_dly(mdly_r[c]),
      .ramp_step(step_r[c]),
      .ramp_init(init_r[c]),
      .ms_tick(tick_r),
      .req(req_w[c]),
      .modulating(mod_s),
      .ack_pulse(ack_pulse),
      .speed(SPEED),
      .ind(ind_w[c]),
      .trip(trip_w[c])
    );
  end
  assign rd_acc[0] = '0;

  // output routing: several channels may share one output, ORed
  for (genvar k = 0; k < NUM_DO; k++) begin : g_do
    logic [NUM_CH-1:0] drv;
    for (genvar c = 0; c < NUM_CH; c++) begin : g_m
      assign drv[c] = ind_w[c] && (out_sel[c] == SEL_W'(k));
    end
    assign dout_nxt[k] = |drv;
  end

  // events: trip rising in low half, supervision start in high half
  wire [EVT_W-1:0] evt = {ind_w & ~ind_d_r, trip_w & ~trip_d_r};
  wire [EVT_W-1:0] w1c = (apb_wr && PADDR == OFF_STATUS) ? PWDATA[EVT_W-1:0] : '0;
  assign status_nxt = (status_r & ~w1c) | evt;

  // read data captured in setup so it comes from a flop in access
  wire [DATA_W-1:0] glb_rd =
    (PADDR == OFF_STATUS) ? DATA_W'(status_r) :
    (PADDR == OFF_MASK) ? DATA_W'(mask_r) :
    (PADDR == OFF_STATE) ? DATA_W'({mod_s, req_w, trip_w, ind_w}) :
    (PADDR == OFF_CFG) ? DATA_W'(cfg_enc_r) : '0;
  wire [DATA_W-1:0] rd_mux = hit ? (rd_acc[NUM_CH] | glb_rd) : '0;

  // global registers and output flops
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      status_r <= '0;
      mask_r <= '0;
      cfg_enc_r <= 1'b0;
      ind_d_r <= '0;
      trip_d_r <= '0;
      dout_r <= '0;
      prdata_r <= '0;
    end else begin
      status_r <= status_nxt;
      if (apb_wr && PADDR == OFF_MASK) mask_r <= PWDATA[EVT_W-1:0];
      if (apb_wr && PADDR == OFF_CFG) cfg_enc_r <= PWDATA[CFG_ENC_BIT];
      ind_d_r <= ind_w;
      trip_d_r <= trip_w;
      dout_r <= dout_nxt;
      if (apb_setup && !PWRITE) prdata_r <= rd_mux;
    end
  end

  assign PRDATA = prdata_r;
  assign PREADY = 1'b1;
  assign PSLVERR = apb_access && !hit;
  assign DOUT = dout_r;
  assign TRIP = |trip_w;
  assign IRQ = |(status_r & mask_r);

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);

  // helper: one-hot of channel 0 output select, for routing checks
  wire [NUM_DO-1:0] oh0_w = NUM_DO'(1) << out_sel[0];

  dout_route_a: assert property (ind_w[0] |=> |(DOUT & $past(oh0_w)))
    else $error("indication did not reach its selected output");
  disabled_off_a: assert property (!en_w[3] ##1 !en_w[3] |-> !ind_w[3] && !trip_w[3])
    else $error("disabled channel still supervising or tripped");
  req_route_a: assert property ((in_sel[0] == 3'h0 && $rose(DIN[0])) ##1 (DIN[0] && in_sel[0] == 3'h0) |=> req_w[0])
    else $error("selected input did not reach channel request");
  trip_event_a: assert property ($rose(trip_w[2]) |=> status_r[2] ##0 (IRQ || !mask_r[2]))
    else $error("trip event not latched into status");
  trip_out_a: assert property (trip_w[0] |-> TRIP)
    else $error("channel trip not driven onto trip output");
endmodule

// File: tb/slm_drive_model.sv
/*
  Behavioural drive control unit with speed feedback: slews the measured speed
  toward a commanded target and reports modulation.
  Assumes the bench sets target, slew rate and modulation from SYS_CLK edges.
*/
`timescale 1ns/100ps
module slm_drive_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic signed [slm_pkg::SPD_W-1:0] target,
  input wire logic [slm_pkg::SPD_W-1:0] rate,
  input wire logic mod_on,
  output logic signed [slm_pkg::SPD_W-1:0] speed,
  output logic modulating
);
  import slm_pkg::*;
  logic signed [SPD_W:0] diff;
  logic signed [SPD_W:0] step;
  // one extra bit so large jumps cannot wrap
  assign diff = {target[SPD_W-1], target} - {speed[SPD_W-1], speed};
  assign step = {1'b0, rate};
  // drive's own slew up or down by rate per cycle; coasts at held speed with modulation off
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      speed <= '0;
      modulating <= 1'b0;
    end else begin
      modulating <= mod_on;
      if (!mod_on) speed <= speed;
      else if (diff > step) speed <= speed + rate;
      else if (diff < -step) speed <= speed - rate;
      else speed <= target;
    end
  end
endmodule

// File: tb/tb_slm_top.sv
/*
  Self-checking bench for the speed limit monitor: APB master, pin stimulus,
  drive model, read-back scoreboard queue.
  Assumes zero or more APB wait states and a short tick of 4 cycles.
*/
`timescale 1ns/100ps
module tb_slm_top;
  import slm_pkg::*;
  logic SYS_CLK, RST, psel, penable, pwrite, mod_on, ack_btn;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata;
  logic pready, pslverr, trip, irq, modulating;
  logic [NUM_DI-1:0] din;
  logic [NUM_DO-1:0] dout;
  logic signed [SPD_W-1:0] tgt, speed;
  logic [SPD_W-1:0] rate;
  logic [32:0] exp_q[$];
  int error_cnt, n_checks, seed, c, i;

  slm_top #(.TICK_CYCLES(4)) slm_top_inst (.SYS_CLK(SYS_CLK), .RST(RST), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .SPEED(speed), .DIN(din), .MODULATING(modulating), .ACK_BUTTON(ack_btn), .DOUT(dout), .TRIP(trip),
    .IRQ(irq));
  slm_drive_model slm_drive_model_inst (.clk(SYS_CLK), .rst(RST), .target(tgt), .rate(rate),
    .mod_on(mod_on), .speed(speed), .modulating(modulating));

  // free-running 50 MHz clock
  initial begin
    SYS_CLK = 1'b0;
    forever #10 SYS_CLK = ~SYS_CLK;
  end

  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge SYS_CLK);
  endtask

  // one APB transfer; a read leaves its expected {error, data} in the queue
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [32:0] e);
    if (!w) exp_q.push_back(e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge SYS_CLK);
    penable <= 1'b1;
    @(posedge SYS_CLK);
    while (pready !== 1'b1) @(posedge SYS_CLK);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge SYS_CLK);
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, {1'b0, e});
  endtask

  // drop request, stop, press acknowledge, clear status
  task automatic clear();
    tgt <= '0;
    din <= '0;
    cyc(10);
    ack_btn <= 1'b1;
    cyc(4);
    ack_btn <= 1'b0;
    cyc(6);
    chk(33'(trip), 33'h0);
    wr(OFF_STATUS, 32'hFF);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // scoreboard: each completed read is matched to the oldest note
  always @(posedge SYS_CLK) begin
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) chk({pslverr, prdata}, exp_q.pop_front());
  end

  // watchdog, far beyond the expected run of under a thousand cycles
  initial begin
    #400000;
    error_cnt++;
    wrap_up();
  end

  initial begin
    {RST, mod_on, rate} = {1'b1, 1'b1, 16'h0FA0};
    {psel, penable, pwrite, paddr, pwdata, din, ack_btn, tgt} = '0;
    {error_cnt, n_checks, seed} = {32'h0, 32'h0, 32'd61554};
    cyc(5);
    RST <= 1'b0;
    cyc(1);
    rd(OFF_CTRL, 32'h01D);
    rd(CH_STRIDE | OFF_CTRL, 32'h13D);
    rd(OFF_LIM_NEG, 32'hF830);
    rd(OFF_LIM_POS, 32'h07D0);
    rd(OFF_TRIP_NEG, 32'hF63C);
    rd(OFF_TRIP_POS, 32'h09C4);
    rd(OFF_ACT_DLY, 32'h0FA0);
    rd(OFF_MOD_DLY, 32'h0);
    rd(OFF_RAMP, 32'h00640008);
    apb(1'b0, 8'h90, 32'h0, 33'h100000000);
    wr(OFF_STATE, 32'hFFFF);
    rd(OFF_STATE, 32'h1000);
    $display("test reset values done");
    // each channel from its own input to its own output, interrupt masked first
    for (c = 0; c < NUM_CH; c++) begin
      wr(OFF_MASK, (c == 0) ? 32'h0 : 32'hFF);
      din <= 8'(1 << c);
      cyc(8);
      chk(33'(dout), 33'(1 << c));
      chk(33'(irq), 33'(c != 0));
      rd(OFF_STATUS, 32'(1 << (4 + c)));
      wr(OFF_STATUS, 32'(1 << (4 + c)));
      chk(33'(irq), 33'h0);
      din <= '0;
      cyc(8);
      chk(33'(dout), 33'h0);
    end
    wr(OFF_STATUS, 32'hFF);
    $display("test channels done");
    // random speeds inside the limits never trip
    din <= 8'h01;
    cyc(8);
    for (i = 0; i < 20; i++) begin
      tgt <= 16'($random(seed) % 2000);
      cyc(3);
      chk(33'({trip, dout[0]}), 33'h1);
    end
    clear();
    // forward then reverse trip while supervising
    for (i = 0; i < 2; i++) begin
      din <= 8'h01;
      cyc(8);
      tgt <= i ? -16'sd2600 : 16'sd2600;
      cyc(6);
      chk(33'(trip), 33'h1);
      rd(OFF_STATUS, 32'h11);
      clear();
    end
    $display("test trips done");
    // time monitoring on channel 1, delay well below the 4000 ms reset default
    wr(CH_STRIDE | OFF_CTRL, 32'h135);
    wr(CH_STRIDE | OFF_ACT_DLY, 32'h5);
    tgt <= 16'sd2200;
    cyc(3);
    din <= 8'h02;
    cyc(8);
    chk(33'(dout[1]), 33'h0);
    cyc(32);
    chk(33'({trip, dout[1]}), 33'h1);
    clear();
    // modulation loss in the ramp: delayed, ignored with encoder, immediate
    wr(8'h40 | OFF_MOD_DLY, 32'h3);
    for (i = 0; i < 3; i++) begin
      wr(OFF_CFG, 32'(i == 1));
      if (i == 2) wr(8'h40 | OFF_CTRL, 32'h24D);
      tgt <= 16'sd2200;
      cyc(3);
      din <= 8'h04;
      cyc(6);
      mod_on <= 1'b0;
      cyc(8);
      chk(33'(trip), 33'(i == 2));
      cyc(30);
      chk(33'(trip), 33'(i != 1));
      mod_on <= 1'b1;
      clear();
    end
    $display("test modulation loss done");
    // held speed exceeds a falling envelope after a short allowance
    wr(8'h40 | OFF_RAMP, 32'h00020008);
    tgt <= 16'sd2200;
    cyc(3);
    din <= 8'h04;
    cyc(6);
    chk(33'(trip), 33'h0);
    cyc(40);
    chk(33'(trip), 33'h1);
    clear();
    // a disabled channel ignores its request entirely
    wr(8'h60 | OFF_CTRL, 32'h37C);
    tgt <= 16'sd2600;
    din <= 8'h08;
    cyc(10);
    chk(33'({trip, dout[3]}), 33'h0);
    clear();
    $display("test ramp and disable done");
    // manual acknowledge on channel 0: indication holds until the button
    wr(OFF_CTRL, 32'h019);
    din <= 8'h01;
    cyc(8);
    din <= 8'h00;
    cyc(8);
    chk(33'(dout[0]), 33'h1);
    clear();
    chk(33'(dout[0]), 33'h0);
    $display("test manual acknowledge done");
    wrap_up();
  end
endmodule
